// *** qdl_core.sv ***
// Load logic of a quad 8-bit DAC: serial or parallel input registers,
// transparent DAC registers, clear and power shutdown control.
// Assumes every pin is asynchronous to mclk_i and that the serial clock
// is much slower than mclk_i so that its edges can be found by sampling.
// Contract
// R1 - Serial word is 12 bits, MSB first.
// R2 - Shift data on each serial clock rising edge.
// R3 - Shift only while chip select is low.
// R4 - Decode only the final 12 bits shifted.
// R5 - Host may send two right-justified bytes.
// R6 - Chip select rise loads channel or shutdown.
// R7 - Off bits active low; data still loads.
// R8 - Both off bits shut down all channels.
// R9 - Shutdown keeps DAC register contents unchanged.
// R10 - Clear zeroes all input and DAC registers.
// R11 - Update low makes DAC registers transparent.
// R12 - Host ties clear high, update low if unused.
// R13 - Floating serial pin selects hardware shutdown.
// R14 - Power-on reset zeroes all registers.
// R15 - DAC registers stay zero until loaded.
// R16 - Parallel DAC registers change only on update.
// R17 - Parallel bus is 8 bits, MSB highest.
// R18 - Select bits pick input register during write.
// R19 - Host holds bus stable while write low.
// R20 - Hardware shutdown never alters DAC registers.
// R21 - Word is select, two off bits, data.
`timescale 1ns/10ps
module qdl_core #(
	// PARALLEL selects the byte-wide variant, which ignores the serial pins;
	// the serial variant in turn ignores the write strobe and the bus.
	parameter bit PARALLEL = 1'b0
) (
	input  wire logic            mclk_i,
	input  wire logic            rst_i,
	input  wire logic            sclk_i,
	input  wire logic            cs_n_i,
	input  wire logic            serial_in_powerdown_pin_i,
	input  wire logic            hw_powerdown_detect_i,
	input  wire logic            wr_n_i,
	input  wire logic            channel_sel_hi_i,
	input  wire logic            channel_sel_lo_powerdown_pin_i,
	input  wire logic [7:0]      par_bus_i,
	input  wire logic            async_zero_all_n_i,
	input  wire logic            output_update_n_i,
	output qdl_pkg::qdl_codes_t  dac_code_o,
	output logic [3:0]           chan_off_o
);
	import qdl_pkg::*;

	// The field layout of the word type must match the shift register.
	if ($bits(qdl_word_t) != WORD_BITS) begin : g_bad_word
		$error("Serial word type does not match the shift register width.");
	end

	// Synchroniser stages and the edge history of the link pins.
	qdl_pins_t  pins_raw;
	qdl_pins_t  sync1_q;
	qdl_pins_t  sync2_q;
	logic       sclk_prev_q;
	logic       cs_prev_q;
	logic       sclk_rise;
	logic       cs_rise;
	// Serial shift register and its decoded view.
	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] shift_d;
	qdl_word_t  word;
	// Input registers, DAC registers and shutdown state.
	qdl_codes_t inreg_q;
	qdl_codes_t inreg_d;
	qdl_codes_t dac_q;
	qdl_codes_t dac_d;
	logic [3:0] off_q;
	logic [3:0] off_d;
	logic [3:0] out_off_q;
	logic [3:0] out_off_d;
	logic       hw_off;

	// Gather pins; the powerdown detect is the window comparator result.
	assign pins_raw = '{
		sclk:           sclk_i,
		cs_n:           cs_n_i,
		ser_data:       serial_in_powerdown_pin_i,
		powerdown:      hw_powerdown_detect_i,
		wr_n:           wr_n_i,
		channel_sel_hi: channel_sel_hi_i,
		channel_sel_lo: channel_sel_lo_powerdown_pin_i,
		zero_n:         async_zero_all_n_i,
		upd_n:          output_update_n_i,
		bus:            par_bus_i
	};

	// Two-stage synchroniser; only the second stage is read by logic.
	// Reading the first stage would let a half-settled pin reach several
	// decoders at once, and they could disagree about its value.
	// Clear and update therefore act two to three cycles after the pin.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q     <= '{sclk: 1'b0, cs_n: 1'b1, wr_n: 1'b1, zero_n: 1'b1,
			                 upd_n: 1'b1, default: '0};
			sync2_q     <= '{sclk: 1'b0, cs_n: 1'b1, wr_n: 1'b1, zero_n: 1'b1,
			                 upd_n: 1'b1, default: '0};
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			sync1_q     <= pins_raw;
			sync2_q     <= sync1_q;
			sclk_prev_q <= sync2_q.sclk;
			cs_prev_q   <= sync2_q.cs_n;
		end
	end

	// Edge detection works on the synchronised copies only.
	assign sclk_rise = sync2_q.sclk & ~sclk_prev_q;
	assign cs_rise   = sync2_q.cs_n & ~cs_prev_q;
	assign word      = qdl_word_t'(shift_q); // R21
	// Hardware shutdown comes from the floating-pin comparator.
	assign hw_off    = sync2_q.powerdown; // R13

	// Shift register: surplus leading bits simply fall off the top, so a
	// host sending two right-justified bytes ends with the right word.
	always_comb begin
		shift_d = shift_q;
		if (!sync2_q.cs_n && sclk_rise) begin // R3
			shift_d = {shift_q[WORD_BITS-2:0], sync2_q.ser_data}; // R1 R2 R4
		end
	end

	// Input registers and software shutdown flags.
	always_comb begin
		inreg_d = inreg_q;
		off_d   = off_q;
		// A serial word commits only on the chip select rise, never mid-frame.
		// The single-off bit adds its channel to those already off; only a
		// word with both off bits high wakes the outputs again.
		if (!PARALLEL && cs_rise) begin
			inreg_d[word.chan_sel] = word.data; // R6 R7
			if (!word.all_channel_off_bit) begin
				off_d = 4'hF; // R8
			end else if (!word.single_channel_off_bit) begin
				off_d[word.chan_sel] = 1'b1;
			end else begin
				off_d = 4'h0;
			end
		end
		if (PARALLEL && !sync2_q.wr_n) begin
			// Level-sensitive write follows the bus while the strobe is low.
			inreg_d[{sync2_q.channel_sel_hi, sync2_q.channel_sel_lo}] = sync2_q.bus; // R17 R18
		end
		// Clear comes last so that it beats any load in the same cycle.
		if (!sync2_q.zero_n) begin
			inreg_d = '0; // R10
		end
	end

	// DAC registers: transparent while update is low, frozen while the
	// channel is shut down so the held code returns on wakeup.
	// Clear is synchronised, so a pulse shorter than one clock period
	// may be missed; hosts must hold it low at least that long.
	always_comb begin
		dac_d = dac_q;
		for (int i = 0; i < CHANNELS; i++) begin
			if (!sync2_q.upd_n && !off_q[i] && !hw_off) begin // R11 R16 R9 R20 R15
				dac_d[i] = inreg_q[i];
			end
		end
		if (!sync2_q.zero_n) begin
			dac_d = '0; // R10
		end
	end

	// Output driver disables combine software and hardware shutdown.
	// Registered so the driver disables never glitch while the word decodes.
	always_comb begin
		out_off_d = off_q | {CHANNELS{hw_off}}; // R8 R13
	end

	// Register everything; power-on reset zeroes all codes.
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_q   <= '0;
			inreg_q   <= {CHANNELS{CODE_RST}}; // R14
			dac_q     <= {CHANNELS{CODE_RST}}; // R14
			off_q     <= OFF_RST;
			out_off_q <= OFF_RST;
		end else begin
			shift_q   <= shift_d;
			inreg_q   <= inreg_d;
			dac_q     <= dac_d;
			off_q     <= off_d;
			out_off_q <= out_off_d;
		end
	end

	assign dac_code_o = dac_q;
	assign chan_off_o = out_off_q;

	// The assertions watch the synchronised view, so their timing counts
	// system cycles after the second synchroniser stage.

	// Shifting never happens with chip select high.
	a_shift_gated: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
		sync2_q.cs_n |=> shift_q == $past(shift_q))
		else $error("Shift register moved with chip select high.");

	// Each sampled bit enters at the bottom and the rest move up.
	a_shift_order: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
		(!sync2_q.cs_n && sclk_rise) |=>
		(shift_q[0] == $past(sync2_q.ser_data)) &&
		(shift_q[WORD_BITS-1:1] == $past(shift_q[WORD_BITS-2:0])))
		else $error("Serial bit was not shifted in MSB first.");

	// Chip select rise stores the data field in the addressed channel.
	a_word_load: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
		(!PARALLEL && cs_rise && sync2_q.zero_n) |=>
		inreg_q[$past(word.chan_sel)] == $past(word.data))
		else $error("Serial word did not reach its input register.");

	// Both off bits low turn off every channel within two cycles.
	a_all_off: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
		(!PARALLEL && cs_rise && !word.all_channel_off_bit &&
		 !word.single_channel_off_bit) |=> off_q == 4'hF ##1 chan_off_o == 4'hF)
		else $error("Full shutdown word did not disable all outputs.");

	// A shut down channel 0 keeps its DAC code.
	a_off_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
		(off_q[0] && sync2_q.zero_n) |=> dac_q[0] == $past(dac_q[0]))
		else $error("DAC code changed during software shutdown.");

	// Clear zeroes every input and DAC register on the next edge.
	a_clear_zero: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
		!sync2_q.zero_n |=> (inreg_q == '0) && (dac_q == '0))
		else $error("Clear did not zero the registers.");

	// Update low copies the input registers one cycle later.
	a_update_follow: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
		(!sync2_q.upd_n && sync2_q.zero_n && !hw_off && off_q == 4'h0) |=>
		dac_q == $past(inreg_q))
		else $error("DAC registers did not follow the input registers.");

	// Without update low the DAC registers stay put.
	a_update_gate: assert property (@(posedge mclk_i) disable iff (rst_i) // R16
		(sync2_q.upd_n && sync2_q.zero_n) |=> $stable(dac_q))
		else $error("DAC register changed without the update strobe.");

	// Hardware shutdown never disturbs the DAC codes and disables every output.
	a_hw_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // R20
		(hw_off && sync2_q.zero_n) |=> $stable(dac_q) && (chan_off_o == 4'hF))
		else $error("Hardware shutdown altered a DAC code.");

	// Right after power-on reset every code reads zero.
	a_reset_zero: assert property (@(posedge mclk_i) // R14
		$fell(rst_i) |-> (dac_q == '0) && (inreg_q == '0))
		else $error("Power-on reset left a nonzero code.");

	// Outside a chip select rise the serial variant leaves the input side alone.
	a_serial_gate: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
		(!PARALLEL && !cs_rise && sync2_q.zero_n) |=> $stable(inreg_q) && $stable(off_q))
		else $error("Serial input side changed without a chip select rise.");

	// A single-off word shuts down the addressed channel.
	a_single_off: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
		(!PARALLEL && cs_rise && word.all_channel_off_bit && !word.single_channel_off_bit) |=>
		off_q[$past(word.chan_sel)])
		else $error("Single-off word did not shut down its channel.");

	// Both off bits high wake every channel again.
	a_all_on: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
		(!PARALLEL && cs_rise && word.all_channel_off_bit && word.single_channel_off_bit) |=>
		off_q == 4'h0)
		else $error("Wake word left a channel shut down.");

	// The parallel variant has no software shutdown, only the hardware one.
	a_par_no_off: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
		PARALLEL |-> off_q == 4'h0)
		else $error("Parallel variant set a software shutdown flag.");

	// Parallel variant: a low write strobe stores the bus in the selected register.
	a_par_write: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
		(PARALLEL && !sync2_q.wr_n && sync2_q.zero_n) |=>
		inreg_q[$past({sync2_q.channel_sel_hi, sync2_q.channel_sel_lo})] ==
		$past(sync2_q.bus))
		else $error("Parallel write did not reach the selected input register.");

	// Parallel variant: with the strobe high the input registers hold.
	a_par_gate: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
		(PARALLEL && sync2_q.wr_n && sync2_q.zero_n) |=> $stable(inreg_q))
		else $error("Parallel input register changed with the write strobe high.");

	// Every shut down channel keeps its code, not only the first one.
	for (genvar g = 0; g < CHANNELS; g++) begin : g_chan_hold
		a_chan_hold: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
			(off_q[g] && sync2_q.zero_n) |=> dac_q[g] == $past(dac_q[g]))
			else $error("DAC code changed while its channel was shut down.");
	end

	// Main scenarios.
	c_serial_load: cover property (@(posedge mclk_i) disable iff (rst_i)
		cs_rise && word.all_channel_off_bit && word.single_channel_off_bit);
	c_single_off: cover property (@(posedge mclk_i) disable iff (rst_i)
		cs_rise && word.all_channel_off_bit && !word.single_channel_off_bit);
	c_update: cover property (@(posedge mclk_i) disable iff (rst_i)
		!sync2_q.upd_n && (dac_q != dac_d));
	c_hw_off: cover property (@(posedge mclk_i) disable iff (rst_i)
		$rose(hw_off));
	c_par_write: cover property (@(posedge mclk_i) disable iff (rst_i)
		PARALLEL && !sync2_q.wr_n);

endmodule : qdl_core

// *** qdl_host.sv ***
// Host model that drives the three-wire serial link of the load interface.
// Assumes mclk_i from the bench; link signals move on its falling edge.
`timescale 1ns/10ps
module qdl_host (
	input  wire logic mclk_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdo_o
);
	// The link idles with its clock low and still, and chip select high.
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdo_o  = 1'b0;
	end
	// Half of the 80 ns link period is eight system cycles.
	task automatic half;
		repeat (8) @(negedge mclk_i);
	endtask : half
	// Sends n bits MSB first; sel low keeps chip select high throughout.
	task automatic send(input logic [15:0] w, input int n, input bit sel);
		cs_n_o = !sel;
		for (int i = n - 1; i >= 0; i--) begin
			sdo_o = w[i];
			half();
			sclk_o = 1'b1;
			half();
			sclk_o = 1'b0;
		end
		half();
		cs_n_o = 1'b1;
		sdo_o  = ~sdo_o; // A released line must not show the last bit.
	endtask : send
endmodule : qdl_host

// *** qdl_pkg.sv ***
// Shared constants and carrier types for the quad DAC load interface.
// Assumes one system clock domain; all pins arrive asynchronously to it.
package qdl_pkg;

	// Serial word geometry, most significant bit first.
	localparam int WORD_BITS   = 12;
	localparam int DATA_BITS   = 8;
	localparam int CHANNELS    = 4;
	localparam int ADDR_POS    = 10;
	localparam int ALL_OFF_POS = 9;
	localparam int ONE_OFF_POS = 8;
	localparam int DATA_POS    = 0;

	// Reset values of the register file.
	localparam logic [7:0] CODE_RST = 8'h00;
	localparam logic [3:0] OFF_RST  = 4'h0;

	// Decoded serial word, laid out exactly as it leaves the shift register.
	typedef struct packed {
		logic [1:0] chan_sel;
		logic       all_channel_off_bit;
		logic       single_channel_off_bit;
		logic [7:0] data;
	} qdl_word_t;

	// The four channel codes travel together.
	typedef logic [CHANNELS-1:0][DATA_BITS-1:0] qdl_codes_t;

	// Every pin that crosses into the clock domain, grouped for synchronising.
	typedef struct packed {
		logic       sclk;
		logic       cs_n;
		logic       ser_data;
		logic       powerdown;
		logic       wr_n;
		logic       channel_sel_hi;
		logic       channel_sel_lo;
		logic       zero_n;
		logic       upd_n;
		logic [7:0] bus;
	} qdl_pins_t;

endpackage : qdl_pkg

// *** tb_quad_dac_load_interface.sv ***
// Self-checking bench for the serial and parallel variants of the load interface.
// Assumes qdl_pkg and the host model; expectations come from a local model.
`timescale 1ns/10ps
module tb_quad_dac_load_interface;
	import qdl_pkg::*;
	logic        mclk_i = 1'b0;
	logic        rst_i  = 1'b1;
	logic        sclk, cs_n, sdo;
	logic        hw_pd  = 1'b0;
	logic        sel_hi = 1'b0;
	logic        sel_lo = 1'b0;
	logic        zero_n = 1'b1;
	logic        upd_n  = 1'b0;
	logic        wr_n   = 1'b1;
	logic [7:0]  bus    = 8'h00;
	logic [3:0]  off, e_off, p_off, nib;
	logic [7:0]  pb;
	qdl_codes_t  codes, e_in, e_dac;
	qdl_codes_t  p_codes, p_in, p_dac;
	logic [71:0] exp_q[$];
	logic [71:0] ev;
	int          err_total = 0;
	int          compares  = 0;
	int          cyc       = 0;

	always #2.5 mclk_i = ~mclk_i;

	qdl_host i_host (.mclk_i(mclk_i), .sclk_o(sclk), .cs_n_o(cs_n), .sdo_o(sdo));
	qdl_core #(.PARALLEL(1'b0)) i_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.serial_in_powerdown_pin_i(sdo), .hw_powerdown_detect_i(hw_pd),
		.wr_n_i(wr_n), .channel_sel_hi_i(sel_hi), .channel_sel_lo_powerdown_pin_i(sel_lo),
		.par_bus_i(bus), .async_zero_all_n_i(zero_n), .output_update_n_i(upd_n),
		.dac_code_o(codes), .chan_off_o(off));
	// The parallel variant shares every pin and must ignore the serial link.
	qdl_core #(.PARALLEL(1'b1)) i_dut_par (
		.mclk_i(mclk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.serial_in_powerdown_pin_i(sdo), .hw_powerdown_detect_i(hw_pd),
		.wr_n_i(wr_n), .channel_sel_hi_i(sel_hi), .channel_sel_lo_powerdown_pin_i(sel_lo),
		.par_bus_i(bus), .async_zero_all_n_i(zero_n), .output_update_n_i(upd_n),
		.dac_code_o(p_codes), .chan_off_o(p_off));

	// Prints the verdict and ends the run.
	task automatic tally_and_finish;
		if (err_total == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	// Transparent DAC registers follow unless their channel is shut down.
	task automatic sync;
		for (int c = 0; c < 4; c++) begin
			if (!upd_n && !e_off[c] && !hw_pd) e_dac[c] = e_in[c];
			if (!upd_n && !hw_pd) p_dac[c] = p_in[c];
		end
	endtask : sync

	// Lets the pipeline settle, then notes the expected outputs.
	task automatic note;
		repeat (12) @(negedge mclk_i);
		{sel_hi, sel_lo, bus} = 10'($urandom); // Strobe is high, so both ignore this.
		exp_q.push_back({e_off | {4{hw_pd}}, e_dac, {4{hw_pd}}, p_dac});
		@(negedge mclk_i);
	endtask : note

	// Applies one committed serial word to the local model.
	task automatic apply(input logic [1:0] ch, input logic al, sg, input logic [7:0] d);
		e_in[ch] = d;
		e_off = !al ? 4'hF : (!sg ? e_off | (4'h1 << ch) : 4'h0);
		sync();
		note();
	endtask : apply

	// Sends one word behind four surplus bits and updates the model.
	task automatic word(input logic [1:0] ch, input logic al, sg, input logic [7:0] d);
		i_host.send({4'($urandom), ch, al, sg, d}, 16, 1'b1);
		apply(ch, al, sg, d);
	endtask : word

	// Writes one byte on the parallel port; bus and select hold while the strobe is low.
	task automatic pwrite(input logic [1:0] ch, input logic [7:0] d);
		{sel_hi, sel_lo, bus} = {ch, d};
		@(negedge mclk_i);
		wr_n = 1'b0;
		repeat (4) @(negedge mclk_i);
		wr_n = 1'b1;
		p_in[ch] = d;
		sync();
		note();
	endtask : pwrite

	// Compares every noted result with the outputs and guards against hangs.
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (exp_q.size() != 0) begin
			ev = exp_q.pop_front();
			compares++;
			if (ev !== {off, codes, p_off, p_codes}) begin
				$display("mismatch t=%0t exp=%h got=%h", $time, ev, {off, codes, p_off, p_codes});
				err_total++;
			end
		end
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// Main sequence.
	initial begin
		void'($urandom(32'hF8E0));
		e_in  = '0;
		e_dac = '0;
		e_off = 4'h0;
		p_in  = '0;
		p_dac = '0;
		repeat (5) @(negedge mclk_i);
		rst_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		note();
		for (int c = 0; c < 4; c++) begin
			word(c[1:0], 1'b1, 1'b1, 8'($urandom));
			pwrite(c[1:0], 8'($urandom));
		end
		i_host.send(16'($urandom), 12, 1'b0);
		note();
		// A short frame keeps the last word's low nibble on top, unless the
		// burst with chip select high was wrongly shifted in.
		nib = e_in[3][3:0];
		pb  = 8'($urandom);
		i_host.send({8'h00, pb}, 8, 1'b1);
		apply(nib[3:2], nib[1], nib[0], pb);
		upd_n = 1'b1;
		word(2'd1, 1'b1, 1'b1, 8'hA5);
		pwrite(2'd2, 8'h96);
		upd_n = 1'b0;
		sync();
		note();
		word(2'd2, 1'b1, 1'b0, 8'h3C);
		word(2'd2, 1'b1, 1'b1, 8'hC3);
		word(2'd0, 1'b0, 1'b0, 8'h5A);
		word(2'd3, 1'b1, 1'b1, 8'h0F);
		hw_pd = 1'b1;
		i_host.send({6'h3F, 2'b11, 8'h77}, 16, 1'b1);
		e_in[3] = 8'h77;
		pwrite(2'd0, 8'h69);
		hw_pd = 1'b0;
		sync();
		note();
		zero_n = 1'b0;
		e_in  = '0;
		e_dac = '0;
		p_in  = '0;
		p_dac = '0;
		note();
		zero_n = 1'b1;
		word(2'd1, 1'b1, 1'b1, 8'hFF);
		repeat (2) @(negedge mclk_i);
		tally_and_finish();
	end
endmodule : tb_quad_dac_load_interface
